//--- src/dpcs_ctrl_status.v
`timescale 1ns/1ps
`default_nettype none
`include "dpcs_consts.vh"
module dpcs_ctrl_status (
   input  wire        clock,                // System clock, 50 MHz
   input  wire        rst,                  // Async reset, active high
   input  wire        two_wire_variant,     // 1 two-wire link, 0 scan-chain
   input  wire        link_clk,             // Probe link clock pin
   input  wire        link_wr,              // Register write request
   input  wire        link_rd,              // Register read request
   input  wire [3:0]  link_addr,            // Register offset
   input  wire [31:0] link_wdata,           // Write data
   output reg  [31:0] link_rdata,           // Read data
   output reg         link_rvalid,          // Read data valid pulse
   input  wire        system_power_ack,     // Async acknowledge
   input  wire        debug_power_ack,      // Async acknowledge
   input  wire        debug_reset_ack,      // Async acknowledge
   output reg         system_power_request, // Power request
   output reg         debug_power_request,  // Power request
   output reg         debug_reset_request,  // Debug reset request
   input  wire        ap_error,             // Transaction error pulse
   input  wire        ap_overrun,           // Overrun pulse
   input  wire        ap_read_done,         // Read or buffer read done
   input  wire        ap_read_ok,           // Its response was OK
   input  wire        wdata_phase_fault,    // Parity/framing fault pulse
   input  wire        write_dropped,        // Accepted write dropped
   output reg         ap_abort              // Abort pulse to the port
);
   wire [`DPCS_SYNC_W-1:0] sync_q;
   wire                    lclk_s;
   wire                    wr_s;
   wire                    rd_s;
   wire [3:0]              addr_s;
   wire [31:0]             wdata_s;
   wire                    sys_ack_s;
   wire                    dbg_ack_s;
   wire                    rst_ack_s;
   wire                    two_wire_s;
   reg                     lclk_d_reg;
   reg                     err_sel_reg;
   reg                     orun_en_reg;
   reg                     fault_reg;
   reg                     overrun_reg;
   reg                     read_good_reg;
   reg                     wr_fault_reg;
   wire                    link_edge;
   wire                    wr_ctrl;
   wire                    wr_abort;
   wire                    clr_fault;
   wire                    clr_overrun;
   wire                    clr_wr_fault;
   wire [31:0]             ctrl_value;
   reg                     sys_req_next;
   reg                     dbg_req_next;
   reg                     rst_req_next;
   reg                     err_sel_next;
   reg                     orun_en_next;
   reg                     fault_next;
   reg                     overrun_next;
   reg                     read_good_next;
   reg                     wr_fault_next;
   reg  [31:0]             rdata_next;

   // Probe-side pins and acknowledges cross into the system clock
   dpcs_sync #(.W(`DPCS_SYNC_W)) u_sync (
      .clock (clock),
      .rst   (rst),
      .d     ({two_wire_variant, debug_reset_ack, debug_power_ack,
               system_power_ack, link_wdata, link_addr, link_rd,
               link_wr, link_clk}),
      .q     (sync_q)
   );
   assign lclk_s     = sync_q[0];
   assign wr_s       = sync_q[1];
   assign rd_s       = sync_q[2];
   assign addr_s     = sync_q[6:3];
   assign wdata_s    = sync_q[38:7];
   assign sys_ack_s  = sync_q[39];
   assign dbg_ack_s  = sync_q[40];
   assign rst_ack_s  = sync_q[41];
   assign two_wire_s = sync_q[42];

   // Requests are taken on the link clock rising edge only
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         lclk_d_reg <= 1'b0;
      end else begin
         lclk_d_reg <= lclk_s;
      end
   end
   assign link_edge = lclk_s & ~lclk_d_reg;
   assign wr_ctrl   = link_edge & wr_s & (addr_s == `DPCS_ADDR_CTRL);
   assign wr_abort  = link_edge & wr_s & (addr_s == `DPCS_ADDR_ABORT);

   assign clr_fault = (wr_abort & wdata_s[`DPCS_ABT_FLT_CLR])
      | (wr_ctrl & ~two_wire_s & wdata_s[`DPCS_BIT_FAULT]);
   assign clr_overrun = (wr_abort & wdata_s[`DPCS_ABT_ORUN_CLR])
      | (wr_ctrl & ~two_wire_s & wdata_s[`DPCS_BIT_OVERRUN]);
   assign clr_wr_fault = wr_abort & wdata_s[`DPCS_ABT_WFLT_CLR];

   // Writable control fields change only on a taken control write
   always @* begin
      sys_req_next = system_power_request;
      dbg_req_next = debug_power_request;
      rst_req_next = debug_reset_request;
      err_sel_next = err_sel_reg;
      orun_en_next = orun_en_reg;
      if (wr_ctrl) begin
         sys_req_next = wdata_s[`DPCS_BIT_SYS_REQ];
         dbg_req_next = wdata_s[`DPCS_BIT_DBG_REQ];
         rst_req_next = wdata_s[`DPCS_BIT_RST_REQ];
         err_sel_next = wdata_s[`DPCS_BIT_ERR_SEL];
         orun_en_next = wdata_s[`DPCS_BIT_ORUN_EN];
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         system_power_request <= 1'b0;
         debug_power_request  <= 1'b0;
         debug_reset_request  <= 1'b0;
         err_sel_reg          <= 1'b0;
         orun_en_reg          <= 1'b0;
      end else begin
         system_power_request <= sys_req_next;
         debug_power_request  <= dbg_req_next;
         debug_reset_request  <= rst_req_next;
         err_sel_reg          <= err_sel_next;
         orun_en_reg          <= orun_en_next;
      end
   end

   // Hardware set wins over a register-write clear in the same cycle; scan-chain mode zeroing of bits 7:6 wins over set
   always @* begin
      fault_next     = fault_reg;
      overrun_next   = overrun_reg;
      read_good_next = read_good_reg;
      wr_fault_next  = wr_fault_reg;
      if (ap_error & ~err_sel_reg) begin
         fault_next = 1'b1;
      end else if (clr_fault) begin
         fault_next = 1'b0;
      end
      if (ap_overrun & orun_en_reg) begin
         overrun_next = 1'b1;
      end else if (clr_overrun) begin
         overrun_next = 1'b0;
      end
      // Scan-chain mode holds bits 7:6 at zero, so no stale flag shows
      if (!two_wire_s) begin
         read_good_next = 1'b0;
      end else if (ap_read_done) begin
         read_good_next = ap_read_ok;
      end
      if (!two_wire_s) begin
         wr_fault_next = 1'b0;
      end else if (wdata_phase_fault | write_dropped) begin
         wr_fault_next = 1'b1;
      end else if (clr_wr_fault) begin
         wr_fault_next = 1'b0;
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         fault_reg     <= 1'b0;
         overrun_reg   <= 1'b0;
         read_good_reg <= 1'b0;
         wr_fault_reg  <= 1'b0;
      end else begin
         fault_reg     <= fault_next;
         overrun_reg   <= overrun_next;
         read_good_reg <= read_good_next;
         wr_fault_reg  <= wr_fault_next;
      end
   end

   assign ctrl_value = {sys_ack_s,
                        system_power_request,
                        dbg_ack_s,
                        debug_power_request,
                        rst_ack_s,
                        debug_reset_request,
                        1'b0,
                        err_sel_reg,
                        16'h0000,
                        wr_fault_reg,
                        read_good_reg,
                        fault_reg,
                        3'h0,
                        overrun_reg,
                        orun_en_reg};

   // Abort is write-only, so other offsets read as zero
   always @* begin
      if (addr_s == `DPCS_ADDR_CTRL) begin
         rdata_next = ctrl_value;
      end else begin
         rdata_next = 32'h0000_0000;
      end
   end

   // Read data holds between reads so a slow probe can still take it
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         link_rdata  <= `DPCS_CTRL_RESET;
         link_rvalid <= 1'b0;
         ap_abort    <= 1'b0;
      end else begin
         link_rvalid <= link_edge & rd_s;
         ap_abort    <= wr_abort & wdata_s[`DPCS_ABT_ABORT];
         if (link_edge & rd_s) begin
            link_rdata <= rdata_next;
         end
      end
   end
endmodule // dpcs_ctrl_status
`default_nettype wire

//--- src/dpcs_consts.vh
`ifndef DPCS_CONSTS_VH
`define DPCS_CONSTS_VH

`define DPCS_ADDR_W          4
`define DPCS_ADDR_ABORT      4'h0
`define DPCS_ADDR_CTRL       4'h4
`define DPCS_CTRL_RESET      32'h0000_0000

`define DPCS_BIT_SYS_ACK     31
`define DPCS_BIT_SYS_REQ     30
`define DPCS_BIT_DBG_ACK     29
`define DPCS_BIT_DBG_REQ     28
`define DPCS_BIT_RST_ACK     27
`define DPCS_BIT_RST_REQ     26
`define DPCS_BIT_ERR_SEL     24
`define DPCS_BIT_WR_FAULT    7
`define DPCS_BIT_READ_GOOD   6
`define DPCS_BIT_FAULT       5
`define DPCS_BIT_OVERRUN     1
`define DPCS_BIT_ORUN_EN     0

`define DPCS_ABT_ORUN_CLR    4
`define DPCS_ABT_WFLT_CLR    3
`define DPCS_ABT_FLT_CLR     2
`define DPCS_ABT_ABORT       0

`define DPCS_SYNC_W          43

`endif

//--- src/dpcs_sync.v
`timescale 1ns/1ps
`default_nettype none
module dpcs_sync #(
   parameter W = 1
) (
   input  wire         clock, // System clock
   input  wire         rst,   // Async reset, active high
   input  wire [W-1:0] d,     // Asynchronous inputs
   output wire [W-1:0] q      // Synchronised outputs
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_reg;
         reg sync_reg;
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else begin
               meta_reg <= d[i];
               sync_reg <= meta_reg;
            end
         end
         assign q[i] = sync_reg;
      end
   endgenerate
endmodule // dpcs_sync
`default_nettype wire

//--- dv/dpcs_probe.sv
`timescale 1ns/1ps
`default_nettype none
module dpcs_probe (
   input  wire logic        clock,      // Bench clock
   output var  logic        link_clk,   // Link clock
   output var  logic        link_wr,    // Write request
   output var  logic        link_rd,    // Read request
   output var  logic [3:0]  link_addr,  // Offset
   output var  logic [31:0] link_wdata  // Write data
);
   initial begin
      link_clk = 1'b0;
      {link_wr, link_rd, link_addr, link_wdata} = 38'h0;
   end
   // Four bench clocks per half of the 160 ns link period
   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
      @(negedge clock);
      {link_wr, link_rd, link_addr, link_wdata} = {w, !w, a, d};
      repeat (3) @(negedge clock);
      link_clk = 1'b1;
      repeat (4) @(negedge clock);
      link_clk = 1'b0;
      // Released lines show inverted data, not a stale copy
      {link_wr, link_rd, link_addr, link_wdata} = {2'b00, ~a, ~d};
   endtask
endmodule // dpcs_probe
`default_nettype wire

//--- dv/dpcs_ctrl_status_props.sv
`timescale 1ns/1ps
`default_nettype none
module dpcs_ctrl_status_props (
   input wire logic        clock,                // System clock
   input wire logic        rst,                  // Async reset
   input wire logic        two_wire_variant,     // Variant pin
   input wire logic        link_wr,              // Write request
   input wire logic [3:0]  link_addr,            // Offset
   input wire logic [31:0] link_wdata,           // Write data
   input wire logic [31:0] link_rdata,           // Read data
   input wire logic        link_rvalid,          // Read valid
   input wire logic        system_power_ack,     // Ack pin
   input wire logic        debug_power_ack,      // Ack pin
   input wire logic        system_power_request, // Request
   input wire logic        debug_power_request,  // Request
   input wire logic        debug_reset_request,  // Request
   input wire logic        ap_abort              // Abort pulse
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire ctl_wr = link_wr && link_addr == 4'h4;
   wire ctl_rd = link_rvalid && link_addr == 4'h4;
   chk_sys_req_src: assert property (
      $changed(system_power_request) |-> ctl_wr
      && link_wdata[30] == system_power_request) else $error("sys req");
   chk_dbg_req_src: assert property (
      $changed(debug_power_request) |-> ctl_wr
      && link_wdata[28] == debug_power_request) else $error("dbg req");
   chk_rst_req_src: assert property (
      $changed(debug_reset_request) |-> ctl_wr
      && link_wdata[26] == debug_reset_request) else $error("rst req");
   chk_sys_ack_read: assert property (
      ctl_rd |-> link_rdata[31] == $past(system_power_ack, 3))
      else $error("sys ack bit");
   chk_dbg_ack_read: assert property (
      ctl_rd |-> link_rdata[29] == $past(debug_power_ack, 3))
      else $error("dbg ack bit");
   chk_abort_cause: assert property (
      ap_abort |-> link_wr && link_addr == 4'h0 && link_wdata[0])
      else $error("abort without write");
   chk_abort_pulse: assert property (
      ap_abort |=> !ap_abort) else $error("abort too long");
   chk_scan_ro_zero: assert property (
      ctl_rd && !two_wire_variant && !$past(two_wire_variant, 4)
      |-> link_rdata[7:6] == 2'b00) else $error("scan bits 7:6");
   chk_read_reserved: assert property (
      link_rvalid |-> (link_rdata & 32'h02ff_ff1c) == 32'h0
      && (link_addr == 4'h4 || link_rdata == 32'h0))
      else $error("reserved bits");
endmodule // dpcs_ctrl_status_props
bind dpcs_ctrl_status dpcs_ctrl_status_props chk (.clock, .rst,
   .two_wire_variant, .link_wr, .link_addr, .link_wdata, .link_rdata,
   .link_rvalid, .system_power_ack, .debug_power_ack,
   .system_power_request, .debug_power_request, .debug_reset_request,
   .ap_abort);
`default_nettype wire

//--- dv/dpcs_ctrl_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module dpcs_ctrl_status_test;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        two_wire_variant = 1'b0;
   logic        ok = 1'b0;
   logic [2:0]  ak = 3'b000;
   logic [4:0]  ev = 5'h00;
   logic        link_clk, link_wr, link_rd, link_rvalid, ap_abort;
   logic        system_power_request, debug_power_request;
   logic        debug_reset_request;
   logic [3:0]  link_addr;
   logic [31:0] link_wdata, link_rdata;
   int          num_errors = 0;
   int          n_checks = 0;
   int          n_rv = 0;
   int          n_ab = 0;
   always #10 clock = ~clock;
   // Pulse counts taken where the outputs are settled
   always @(negedge clock) begin
      if (link_rvalid === 1'b1) n_rv++;
      if (ap_abort === 1'b1) n_ab++;
   end
   dpcs_probe probe (.clock, .link_clk, .link_wr, .link_rd, .link_addr,
      .link_wdata);
   dpcs_ctrl_status dut (.clock, .rst, .two_wire_variant, .link_clk,
      .link_wr, .link_rd, .link_addr, .link_wdata, .link_rdata,
      .link_rvalid, .system_power_ack(ak[2]), .debug_power_ack(ak[1]),
      .debug_reset_ack(ak[0]), .system_power_request,
      .debug_power_request, .debug_reset_request, .ap_error(ev[0]),
      .ap_overrun(ev[1]), .ap_read_done(ev[2]), .ap_read_ok(ok),
      .wdata_phase_fault(ev[3]), .write_dropped(ev[4]), .ap_abort);
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      probe.xfer(1'b0, a, 32'h0);
      cmp(link_rdata, exp);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      probe.xfer(1'b1, a, d);
   endtask
   task automatic pulse(input logic [4:0] m);
      @(negedge clock);
      ev = m;
      @(negedge clock);
      ev = 5'h00;
   endtask
   task automatic summarize;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clock);
      rst = 1'b0;
      rd(4'h4, 32'h0);
      wr(4'h4, 32'h5400_0001);
      cmp({29'h0, system_power_request, debug_power_request,
           debug_reset_request}, 32'h7);
      ak = 3'b111;
      rd(4'h4, 32'hfc00_0001);
      pulse(5'h03);
      rd(4'h4, 32'hfc00_0023);
      wr(4'h4, 32'h5400_0023);
      rd(4'h4, 32'hfc00_0001);
      ok = 1'b1;
      wr(4'h4, 32'h5500_0000);
      pulse(5'h0f);
      rd(4'h4, 32'hfd00_0000);
      two_wire_variant = 1'b1;
      wr(4'h4, 32'h5400_0001);
      pulse(5'h0f);
      rd(4'h4, 32'hfc00_00e3);
      wr(4'h4, 32'h5400_0023);
      rd(4'h4, 32'hfc00_00e3);
      wr(4'h0, 32'h0000_001d);
      rd(4'h4, 32'hfc00_0041);
      ok = 1'b0;
      pulse(5'h14);
      rd(4'h4, 32'hfc00_0081);
      wr(4'h4, 32'h0);
      cmp({29'h0, system_power_request, debug_power_request,
           debug_reset_request}, 32'h0);
      rd(4'h4, 32'ha800_0080);
      rd(4'h8, 32'h0);
      cmp(n_rv, 32'd11);
      cmp(n_ab, 32'd1);
      summarize;
   end
   // Whole run needs about 3 us
   initial begin
      #100000;
      num_errors++;
      summarize;
   end
endmodule // dpcs_ctrl_status_test
`default_nettype wire
